// >>> src/ddr3_ctrl_end.sv
// controller end: command release gated by per-constraint cycle counters
`timescale 1ns/1ps
`include "ddr3_timing_regs.svh"

module ddr3_ctrl_end #(
    parameter int ZQ_INTERVAL_CYC = `ZQ_INTERVAL_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    ddr3_cmd_if.ctrl link,
    input wire logic reqValid,
    input wire ddr3_timing_pkg::cmd_e reqCmd,
    input wire ddr3_timing_pkg::addr_t reqAddr,
    output logic reqReady,
    input wire logic pdEnter,
    input wire logic pdExit,
    output logic pdAccept,
    input wire ddr3_timing_pkg::temp_range_e operatingCaseTemperature,
    output logic powerDown,
    output logic dllReady,
    output logic refreshDue,
    output logic zqDue
);
    import ddr3_timing_pkg::*;

    typedef enum logic [1:0] {
        CTL_ACTIVE = 2'b01,
        CTL_PDOWN = 2'b10
    } ctl_state_e;

    typedef struct packed {
        ctl_state_e state;
        logic cke;
        cmd_e cmd;
        addr_t addr;
        logic [3:0] wl;
        logic [3:0] wr;
        logic [3:0] cl;
        logic bc4Fixed;
        logic mprOn;
        logic slowExit;
        logic [9:0] pdWait;
        logic [9:0] dllWait;
        logic [3:0] xpWait;
        logic [5:0] mprWait;
        logic [6:0] zqWait;
        logic [7:0] refTimer;
        logic refDue;
        logic [23:0] zqTimer;
        logic zqDueFlag;
    } ctl_s;

    localparam logic [23:0] ZQ_RELOAD = 24'(ZQ_INTERVAL_CYC);

    ctl_s q;
    ctl_s d;
    logic pdGo;
    logic dllBlock;
    logic mprBlock;
    logic [9:0] issuePd;

    // power-down entry only once the entry, exit and zq calibration counters have run out
    assign pdGo = (q.state == CTL_ACTIVE) && pdEnter && (q.pdWait == 10'h000)
                  && (q.zqWait == 7'h00) && (q.xpWait == 4'h0);

    assign dllBlock = needsDll(reqCmd) && (q.dllWait != 10'h000);
    assign mprBlock = (reqCmd == CMD_MRS) && (q.mprWait != 6'h00);

    // zq short calibration occupies the device for its full window
    assign reqReady = (q.state == CTL_ACTIVE) && !pdGo && (q.xpWait == 4'h0)
                      && (q.zqWait == 7'h00) && !dllBlock && !mprBlock;

    // power-down entry delay that a newly issued command imposes
    always_comb begin
        issuePd = 10'h000;
        case (reqCmd)
            CMD_MRS: issuePd = 10'(`T_MOD_CYC);
            CMD_ACT: issuePd = 10'(`T_ACTPDEN_NCK);
            CMD_PRE: issuePd = 10'(`T_PRPDEN_NCK);
            CMD_REF: issuePd = 10'(`T_REFPDEN_NCK);
            CMD_RD, CMD_RDA: issuePd = 10'(q.cl) + 10'(`RD_PDEN_EXTRA);
            // plain write: recovery in ns converted with round-up
            CMD_WR: issuePd = 10'(q.wl) + 10'(burstOffset(q.bc4Fixed))
                              + 10'(`T_WR_CYC);
            // auto-precharge write: recovery is the mode-register cycle count
            CMD_WRA: issuePd = 10'(q.wl) + 10'(burstOffset(q.bc4Fixed))
                               + 10'(q.wr) + 10'(`WRA_PDEN_EXTRA);
            default: issuePd = 10'h000;
        endcase
    end

    always_comb begin
        d = q;
        d.cmd = CMD_NOP;
        d.addr = q.addr;
        if (q.pdWait != 10'h000) d.pdWait = q.pdWait - 10'h001;
        if (q.dllWait != 10'h000) d.dllWait = q.dllWait - 10'h001;
        if (q.xpWait != 4'h0) d.xpWait = q.xpWait - 4'h1;
        if (q.mprWait != 6'h00) d.mprWait = q.mprWait - 6'h01;
        if (q.zqWait != 7'h00) d.zqWait = q.zqWait - 7'h01;
        if (q.zqTimer != 24'h000000) d.zqTimer = q.zqTimer - 24'h000001;

        case (q.state)
            CTL_ACTIVE: begin
                if (pdGo) begin
                    d.cke = 1'b0;
                    d.state = CTL_PDOWN;
                end else if (reqValid && reqReady) begin
                    d.cmd = reqCmd;
                    d.addr = reqAddr;
                    // pdWait and dllWait keep the longer of what is left and the new need; mprWait and zqWait reload outright
                    d.pdWait = max10(d.pdWait, issuePd);
                    case (reqCmd)
                        CMD_MRS: begin
                            d.wl = reqAddr[`MR_WL_MSB:`MR_WL_LSB];
                            d.wr = reqAddr[`MR_WR_MSB:`MR_WR_LSB];
                            d.cl = reqAddr[`MR_CL_MSB:`MR_CL_LSB];
                            d.bc4Fixed = reqAddr[`MR_BC4_FIXED];
                            d.mprOn = reqAddr[`MR_MPR_ON];
                            d.slowExit = reqAddr[`MR_PD_SLOW];
                            if (reqAddr[`MR_DLL_RESET]) begin
                                d.dllWait = max10(d.dllWait, 10'(`T_DLLK_NCK));
                            end
                        end
                        CMD_RD, CMD_RDA: begin
                            // recovery counts from the end of the register read burst
                            if (q.mprOn) begin
                                d.mprWait = 6'(q.cl) + 6'(`RD_BURST_NCK)
                                            + 6'(`T_MPRR_NCK);
                            end
                        end
                        CMD_ZQCS: begin
                            d.zqWait = 7'(`T_ZQCS_NCK);
                        end
                        default: ;
                    endcase
                end
            end
            CTL_PDOWN: begin
                if (pdExit) begin
                    d.cke = 1'b1;
                    d.state = CTL_ACTIVE;
                    d.xpWait = 4'(`T_XP_CYC);
                    // frozen dll needs the longer exit before locked-dll commands
                    if (q.slowExit) begin
                        d.dllWait = max10(d.dllWait, 10'(`T_XPDLL_CYC));
                    end
                end
            end
            default: begin
                d.state = CTL_ACTIVE;
                d.cke = 1'b1;
            end
        endcase

        // refresh timer reloads from the current temperature range
        if (q.refTimer != 8'h00) begin
            d.refTimer = q.refTimer - 8'h01;
        end else begin
            d.refTimer = refiCycles(operatingCaseTemperature);
        end
        // clear on issue first so an expiry in the same cycle still sets
        if (d.cmd == CMD_REF) d.refDue = 1'b0;
        if (q.refTimer == 8'h00) d.refDue = 1'b1;

        if (d.cmd == CMD_ZQCS) begin
            d.zqDueFlag = 1'b0;
            d.zqTimer = ZQ_RELOAD;
        end
        if (q.zqTimer == 24'h000001) d.zqDueFlag = 1'b1;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            q <= '{state: CTL_ACTIVE, cke: 1'b1, cmd: CMD_NOP, addr: 16'h0000,
                   wl: `RST_WL, wr: `RST_WR, cl: `RST_CL, bc4Fixed: 1'b0,
                   mprOn: 1'b0, slowExit: 1'b0, pdWait: 10'h000,
                   dllWait: 10'(`T_DLLK_NCK), xpWait: 4'h0, mprWait: 6'h00,
                   zqWait: 7'h00, refTimer: 8'(`FLOOR_CYC(`T_REFI_HIGH_NS)),
                   refDue: 1'b0, zqTimer: ZQ_RELOAD, zqDueFlag: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign link.cke = q.cke;
    assign link.cmd = q.cmd;
    assign link.addr = q.addr;
    assign pdAccept = pdGo;
    assign powerDown = (q.state == CTL_PDOWN);
    assign dllReady = (q.dllWait == 10'h000);
    assign refreshDue = q.refDue;
    assign zqDue = q.zqDueFlag;
endmodule // ddr3_ctrl_end

// >>> src/ddr3_timing_regs.svh
// timing counts, mode-register field positions and reset values for the ddr3 command link
`ifndef DDR3_TIMING_REGS_SVH
`define DDR3_TIMING_REGS_SVH

`define CLK_PERIOD_NS 100
`define CEIL_CYC(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FLOOR_CYC(ns) ((ns) / `CLK_PERIOD_NS)
`define MAX_OF(a, b) (((a) > (b)) ? (a) : (b))

// write recovery, least time, rounded up
`define T_WR_NS 15
`define T_WR_CYC `MAX_OF(`CEIL_CYC(`T_WR_NS), 1)
// exit power-down, any command
`define T_XP_NCK 3
`define T_XP_NS 6
`define T_XP_CYC `MAX_OF(`T_XP_NCK, `CEIL_CYC(`T_XP_NS))
// exit frozen-dll power-down to dll-locked commands
`define T_XPDLL_NCK 10
`define T_XPDLL_NS 24
`define T_XPDLL_CYC `MAX_OF(`T_XPDLL_NCK, `CEIL_CYC(`T_XPDLL_NS))
// mrs to power-down entry equals tMOD
`define T_MOD_NCK 12
`define T_MOD_NS 15
`define T_MOD_CYC `MAX_OF(`T_MOD_NCK, `CEIL_CYC(`T_MOD_NS))
`define T_DLLK_NCK 512
`define T_ZQCS_NCK 64
`define T_MPRR_NCK 1
`define T_ACTPDEN_NCK 2
`define T_PRPDEN_NCK 1
`define T_REFPDEN_NCK 1
`define RD_PDEN_EXTRA 5
`define WRA_PDEN_EXTRA 1
`define RD_BURST_NCK 4
`define WSTART_BL8 4
`define WSTART_BC4_MRS 2
`define REF_POSTPONE 9
// average refresh interval per case-temperature range, longest time, rounded down
`define T_REFI_NORMAL_NS 7800
`define T_REFI_EXTENDED_NS 3900
`define T_REFI_HIGH_NS 1950
// zq short-calibration spacing from 0.5 / (tsens*tdrift + vsens*vdrift)
`define ZQ_INTERVAL_MS 128
`define ZQ_INTERVAL_CYC (`ZQ_INTERVAL_MS * 1000000 / `CLK_PERIOD_NS)
`define ZQ_STEP 1
`define ROW_BUSY_CYC 4

// mrs address fields
`define MR_WL_LSB 0
`define MR_WL_MSB 3
`define MR_WR_LSB 4
`define MR_WR_MSB 7
`define MR_CL_LSB 8
`define MR_CL_MSB 11
`define MR_BC4_FIXED 12
`define MR_MPR_ON 13
`define MR_DLL_RESET 14
`define MR_PD_SLOW 15
// write address bit selecting on-the-fly bc4
`define ADDR_BC4_OTF 12

`define RST_WL 4'h5
`define RST_WR 4'h5
`define RST_CL 4'h5
`define RST_IMP 6'h20

`endif

// >>> src/ddr3_timing_pkg.sv
// types and shared helpers for the ddr3 command link
package ddr3_timing_pkg;
`include "ddr3_timing_regs.svh"

    typedef enum logic [3:0] {
        CMD_NOP = 4'h0,
        CMD_ACT = 4'h1,
        CMD_PRE = 4'h2,
        CMD_REF = 4'h3,
        CMD_MRS = 4'h4,
        CMD_RD = 4'h5,
        CMD_RDA = 4'h6,
        CMD_WR = 4'h7,
        CMD_WRA = 4'h8,
        CMD_ZQCS = 4'h9
    } cmd_e;

    typedef enum logic [1:0] {
        TEMP_NORMAL = 2'h0,
        TEMP_EXTENDED = 2'h1,
        TEMP_HIGH = 2'h2
    } temp_range_e;

    typedef logic [15:0] addr_t;

    function automatic logic [3:0] burstOffset(input logic bc4Fixed);
        return bc4Fixed ? 4'(`WSTART_BC4_MRS) : 4'(`WSTART_BL8);
    endfunction

    function automatic logic [7:0] refiCycles(input temp_range_e t);
        case (t)
            TEMP_EXTENDED: return 8'(`FLOOR_CYC(`T_REFI_EXTENDED_NS));
            TEMP_HIGH: return 8'(`FLOOR_CYC(`T_REFI_HIGH_NS));
            default: return 8'(`FLOOR_CYC(`T_REFI_NORMAL_NS));
        endcase
    endfunction

    function automatic logic needsDll(input cmd_e c);
        return (c == CMD_RD) || (c == CMD_RDA);
    endfunction

    function automatic logic [9:0] max10(input logic [9:0] a, input logic [9:0] b);
        return (a > b) ? a : b;
    endfunction
endpackage

// >>> src/ddr3_cmd_if.sv
// command link between the ddr3 controller and the memory device
`timescale 1ns/1ps
interface ddr3_cmd_if;
    import ddr3_timing_pkg::*;
    logic cke;
    cmd_e cmd;
    addr_t addr;
    modport ctrl (output cke, output cmd, output addr);
    modport mem (input cke, input cmd, input addr);
endinterface

// >>> src/ddr3_mem_end.sv
// memory-device end: write start, power-down entry, dll lock, zq calibration, refresh age
`timescale 1ns/1ps
`include "ddr3_timing_regs.svh"
module ddr3_mem_end (
    input wire logic mclk,
    input wire logic rst,
    ddr3_cmd_if.mem link,
    input wire ddr3_timing_pkg::temp_range_e operatingCaseTemperature,
    input wire logic [5:0] zqTarget,
    output logic powerDown,
    output logic writeStart,
    output logic dllLocked,
    output logic zqBusy,
    output logic [5:0] impCode,
    output logic mprActive,
    output logic refreshOverdue
);
    import ddr3_timing_pkg::*;

    typedef enum logic [2:0] {
        DEV_RUN = 3'b001,
        DEV_PD_PENDING = 3'b010,
        DEV_PDOWN = 3'b100
    } dev_state_e;

    typedef struct packed {
        dev_state_e state;
        logic [3:0] wl;
        logic [3:0] wr;
        logic bc4Fixed;
        logic mprOn;
        logic [9:0] dllCnt;
        logic [5:0] busyCnt;
        logic [5:0] wrCnt;
        logic wrPulse;
        logic [6:0] zqCnt;
        logic [5:0] imp;
        logic [10:0] refAge;
        logic overdue;
    } dev_s;

    dev_s q;
    dev_s d;
    logic [10:0] refLimit;

    // only clock edges are counted, so a stopped clock never trips it and a slow one trips it only after refLimit edges
    assign refLimit = 11'(`REF_POSTPONE) * 11'(refiCycles(operatingCaseTemperature));

    always_comb begin
        d = q;
        d.wrPulse = 1'b0;
        if (q.dllCnt != 10'h000) d.dllCnt = q.dllCnt - 10'h001;
        if (q.busyCnt != 6'h00) d.busyCnt = q.busyCnt - 6'h01;
        if (q.wrCnt != 6'h00) begin
            d.wrCnt = q.wrCnt - 6'h01;
            d.wrPulse = (q.wrCnt == 6'h01);
        end
        if (q.zqCnt != 7'h00) begin
            d.zqCnt = q.zqCnt - 7'h01;
            // one step per command is the guaranteed correction, applied at completion
            if (q.zqCnt == 7'h01) begin
                if (q.imp < zqTarget) d.imp = q.imp + 6'(`ZQ_STEP);
                else if (q.imp > zqTarget) d.imp = q.imp - 6'(`ZQ_STEP);
            end
        end
        if (q.refAge != 11'h7FF) d.refAge = q.refAge + 11'h001;
        d.overdue = (q.refAge >= refLimit);
        case (link.cmd)
            CMD_MRS: begin
                d.wl = link.addr[`MR_WL_MSB:`MR_WL_LSB];
                d.wr = link.addr[`MR_WR_MSB:`MR_WR_LSB];
                d.bc4Fixed = link.addr[`MR_BC4_FIXED];
                d.mprOn = link.addr[`MR_MPR_ON];
                if (link.addr[`MR_DLL_RESET]) d.dllCnt = 10'(`T_DLLK_NCK);
            end
            CMD_ACT, CMD_PRE: d.busyCnt = 6'(`ROW_BUSY_CYC);
            CMD_REF: begin
                d.busyCnt = 6'(`ROW_BUSY_CYC);
                d.refAge = 11'h000;
                d.overdue = 1'b0;
            end
            CMD_WR: d.wrCnt = 6'(q.wl) + 6'(burstOffset(q.bc4Fixed));
            CMD_WRA: begin
                d.wrCnt = 6'(q.wl) + 6'(burstOffset(q.bc4Fixed));
                // auto-precharge uses the programmed write recovery, not a ns figure
                d.busyCnt = d.wrCnt + 6'(q.wr) + 6'(`WRA_PDEN_EXTRA);
            end
            CMD_ZQCS: d.zqCnt = 7'(`T_ZQCS_NCK);
            default: ;
        endcase
        case (q.state)
            DEV_RUN: begin
                if (!link.cke) begin
                    if (d.busyCnt != 6'h00 || d.wrCnt != 6'h00) d.state = DEV_PD_PENDING;
                    else d.state = DEV_PDOWN;
                end
            end
            DEV_PD_PENDING: begin
                if (link.cke) d.state = DEV_RUN;
                else if (d.busyCnt == 6'h00 && d.wrCnt == 6'h00) d.state = DEV_PDOWN;
            end
            DEV_PDOWN: begin
                if (link.cke) d.state = DEV_RUN;
            end
            default: d.state = DEV_RUN;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            q <= '{state: DEV_RUN, wl: `RST_WL, wr: `RST_WR, bc4Fixed: 1'b0, mprOn: 1'b0,
                   dllCnt: 10'(`T_DLLK_NCK), busyCnt: 6'h00, wrCnt: 6'h00, wrPulse: 1'b0,
                   zqCnt: 7'h00, imp: `RST_IMP, refAge: 11'h000, overdue: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign powerDown = (q.state == DEV_PDOWN);
    assign writeStart = q.wrPulse;
    assign dllLocked = (q.dllCnt == 10'h000);
    assign zqBusy = (q.zqCnt != 7'h00);
    assign impCode = q.imp;
    assign mprActive = q.mprOn;
    assign refreshOverdue = q.overdue;
endmodule // ddr3_mem_end

// >>> bench/ddr3_link_checker.sv
// assertions on the command link between the controller and memory ends
`timescale 1ns/1ps
`include "ddr3_timing_regs.svh"
module ddr3_link_checker (
    input wire logic mclk,
    input wire logic rst,
    input wire logic cke,
    input wire ddr3_timing_pkg::cmd_e cmd,
    input wire ddr3_timing_pkg::addr_t addr
);
    import ddr3_timing_pkg::*;
    typedef struct packed {
        logic [3:0] wl;
        logic [3:0] wr;
        logic [3:0] cl;
        logic bc4;
        logic mpr;
        logic slow;
        logic cke;
        logic [9:0] pd;
        logic [9:0] dll;
        logic [9:0] mpc;
        logic [9:0] zq;
    } link_state_s;
    link_state_s sQ, sD;
    logic [9:0] need;
    function automatic logic [9:0] dn(input logic [9:0] v);
        return (v != 10'h000) ? v - 10'h001 : v;
    endfunction
    // counters hold cycles still to wait; zero means the next event is legal
    always_comb begin
        need = 10'h000;
        case (cmd)
            CMD_MRS: need = 10'(`T_MOD_CYC);
            CMD_ACT: need = 10'h002;
            CMD_PRE, CMD_REF: need = 10'h001;
            CMD_RD, CMD_RDA: need = 10'(sQ.cl) + 10'h005;
            CMD_WR: need = 10'(sQ.wl) + (sQ.bc4 ? 10'h002 : 10'h004) + 10'(`T_WR_CYC);
            CMD_WRA: need = 10'(sQ.wl) + (sQ.bc4 ? 10'h002 : 10'h004) + 10'(sQ.wr) + 10'h001;
            default: ;
        endcase
        sD = sQ;
        sD.pd = dn(sQ.pd);
        sD.dll = dn(sQ.dll);
        sD.mpc = dn(sQ.mpc);
        sD.zq = dn(sQ.zq);
        sD.cke = cke;
        if (need > sD.pd + 10'h001) sD.pd = need - 10'h001;
        if (cmd == CMD_MRS) begin
            sD.wl = addr[`MR_WL_MSB:`MR_WL_LSB];
            sD.wr = addr[`MR_WR_MSB:`MR_WR_LSB];
            sD.cl = addr[`MR_CL_MSB:`MR_CL_LSB];
            sD.bc4 = addr[`MR_BC4_FIXED];
            sD.mpr = addr[`MR_MPR_ON];
            sD.slow = addr[`MR_PD_SLOW];
            if (addr[`MR_DLL_RESET]) sD.dll = 10'(`T_DLLK_NCK - 1);
        end
        if (cke && !sQ.cke && sQ.slow && sD.dll < 10'(`T_XPDLL_CYC - 1)) begin
            sD.dll = 10'(`T_XPDLL_CYC - 1);
        end
        if ((cmd == CMD_RD || cmd == CMD_RDA) && sQ.mpr) sD.mpc = 10'(sQ.cl) + 10'h004;
        if (cmd == CMD_ZQCS) sD.zq = 10'(`T_ZQCS_NCK - 1);
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            sQ <= '{wl: `RST_WL, wr: `RST_WR, cl: `RST_CL, dll: 10'(`T_DLLK_NCK - 1),
                cke: 1'b1, default: '0};
        end else begin
            sQ <= sD;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    pd_entry_gap_a: assert property ($fell(cke) |-> sQ.pd == 10'h000)
        else $error("power-down entered too soon after a command");
    pd_no_cmd_a: assert property (!cke |-> cmd == CMD_NOP)
        else $error("command sent while clock enable low");
    exit_settle_a: assert property ($rose(cke) |-> (cmd == CMD_NOP) [*3])
        else $error("command too soon after power-down exit");
    dll_wait_a: assert property ((cmd == CMD_RD || cmd == CMD_RDA) |-> sQ.dll == 10'h000)
        else $error("read sent before dll wait expired");
    mpr_recovery_a: assert property (cmd == CMD_MRS |-> sQ.mpc == 10'h000)
        else $error("mode set too soon after mpr read burst");
    zq_busy_a: assert property ((cmd != CMD_NOP || $fell(cke)) |-> sQ.zq == 10'h000)
        else $error("link used during short calibration");
    addr_hold_a: assert property (cmd == CMD_NOP |-> $stable(addr))
        else $error("address moved without a command");
    cmd_awake_a: assert property (cmd != CMD_NOP |=> cke)
        else $error("clock enable dropped right after a command");
    cover property ($fell(cke));
    cover property (cmd == CMD_RD && sQ.slow);
    cover property (cmd == CMD_ZQCS);
endmodule // ddr3_link_checker

// >>> bench/ddr3_command_timing_notes_tb_top.sv
// bench joining the controller and memory ends of the ddr3 command link
`timescale 1ns/1ps
`include "ddr3_timing_regs.svh"
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin failures++; \
    $display("[FAIL] %s expected %0h seen %0h", n, e, s); end end
module ddr3_command_timing_notes_tb_top;
    import ddr3_timing_pkg::*;
    localparam int ZQ_GAP = 200;
    logic mclk, rst, reqValid, reqReady, pdEnter, pdExit, pdAccept, powerDown, dllReady;
    logic refreshDue, zqDue, memPd, writeStart, dllLocked, zqBusy, mprActive, refreshOverdue;
    logic [5:0] zqTarget, impCode;
    cmd_e reqCmd;
    addr_t reqAddr;
    temp_range_e temp;
    int failures, tests_run, cyc, t0, tw, r;
    ddr3_cmd_if link();
    ddr3_ctrl_end #(.ZQ_INTERVAL_CYC(ZQ_GAP)) u_ddr3_ctrl_end (.mclk(mclk), .rst(rst),
        .link(link), .reqValid(reqValid), .reqCmd(reqCmd), .reqAddr(reqAddr),
        .reqReady(reqReady), .pdEnter(pdEnter), .pdExit(pdExit), .pdAccept(pdAccept),
        .operatingCaseTemperature(temp), .powerDown(powerDown), .dllReady(dllReady),
        .refreshDue(refreshDue), .zqDue(zqDue));
    ddr3_mem_end u_ddr3_mem_end (.mclk(mclk), .rst(rst), .link(link),
        .operatingCaseTemperature(temp), .zqTarget(zqTarget), .powerDown(memPd),
        .writeStart(writeStart), .dllLocked(dllLocked), .zqBusy(zqBusy), .impCode(impCode),
        .mprActive(mprActive), .refreshOverdue(refreshOverdue));
    ddr3_link_checker u_ddr3_link_checker (.mclk(mclk), .rst(rst), .cke(link.cke),
        .cmd(link.cmd), .addr(link.addr));
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    always @(posedge mclk) cyc <= cyc + 1;
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // polls just after each edge so registered outputs have settled
    task automatic waitFor(ref logic s, input logic v);
        int n;
        n = 0;
        #1;
        while (s !== v && n < 3000) begin
            @(posedge mclk);
            #1;
            n++;
        end
        `CHK("level reached", v, s)
    endtask
    // returns on the taking edge; the caller drops its request there
    task automatic hs(ref logic rdy);
        waitFor(rdy, 1'b1);
        @(posedge mclk);
        t0 = cyc + 1;
    endtask
    // one idle edge after each take so the request is never reassigned in one step
    task automatic issue(input cmd_e c, input addr_t a);
        reqValid <= 1'b1;
        reqCmd <= c;
        reqAddr <= a;
        hs(reqReady);
        reqValid <= 1'b0;
        @(posedge mclk);
    endtask
    initial begin
        #500000;
        failures++;
        $display("[FAIL] watchdog expected finish seen timeout");
        conclude();
    end
    initial begin
        rst = 1'b1;
        reqValid = 1'b0;
        reqCmd = CMD_NOP;
        reqAddr = 16'h0000;
        pdEnter = 1'b0;
        pdExit = 1'b0;
        temp = TEMP_NORMAL;
        zqTarget = 6'h22;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        #1;
        `CHK("cke", 1'b1, link.cke)
        `CHK("impCode", 6'h20, impCode)
        `CHK("dllLocked", 1'b0, dllLocked)
        `CHK("refreshOverdue", 1'b0, refreshOverdue)
        $display("reset test done");
        for (int i = 0; i < 3; i++) begin
            @(posedge mclk);
            issue(CMD_MRS, {3'h0, 1'(i == 2), 12'h555});
            issue(CMD_WR, {3'h0, 1'(i == 1), 12'h000});
            waitFor(writeStart, 1'b1);
            // one edge through the link register, then latency plus burst offset
            `CHK("write start", 6 + ((i == 2) ? `WSTART_BC4_MRS : `WSTART_BL8), cyc - t0)
        end
        $display("write start test done");
        waitFor(dllReady, 1'b1);
        @(posedge mclk);
        issue(CMD_MRS, 16'h8555);
        issue(CMD_WRA, 16'h0000);
        tw = t0;
        pdEnter <= 1'b1;
        hs(pdAccept);
        pdEnter <= 1'b0;
        @(posedge mclk);
        `CHK("wra to power-down", 1'b1, t0 - tw >= 5 + 4 + 5 + 1)
        repeat (4) @(posedge mclk);
        pdExit <= 1'b1;
        #1;
        `CHK("ctrl power-down", 1'b1, powerDown)
        `CHK("mem power-down", 1'b1, memPd)
        @(posedge mclk);
        tw = cyc + 1;
        pdExit <= 1'b0;
        issue(CMD_RD, 16'h0000);
        `CHK("slow exit to read", 1'b1, t0 - tw >= `T_XPDLL_CYC)
        issue(CMD_MRS, 16'h2555);
        issue(CMD_RD, 16'h0000);
        tw = t0;
        `CHK("mprActive", 1'b1, mprActive)
        issue(CMD_MRS, 16'h0555);
        `CHK("mpr recovery", 1'b1, t0 - tw >= 5 + `RD_BURST_NCK + `T_MPRR_NCK)
        issue(CMD_ACT, 16'h0000);
        issue(CMD_WR, 16'h0000);
        tw = t0;
        pdEnter <= 1'b1;
        hs(pdAccept);
        pdEnter <= 1'b0;
        `CHK("wr to power-down", 1'b1, t0 - tw >= 5 + `WSTART_BL8 + `T_WR_CYC)
        @(posedge mclk);
        pdExit <= 1'b1;
        @(posedge mclk);
        tw = cyc + 1;
        pdExit <= 1'b0;
        issue(CMD_RDA, 16'h0000);
        `CHK("fast exit to read", 1'b1, t0 - tw >= `T_XP_CYC && t0 - tw < `T_XPDLL_CYC)
        issue(CMD_PRE, 16'h0000);
        $display("power-down and dll test done");
        for (int i = 1; i <= 2; i++) begin
            @(posedge mclk);
            issue(CMD_ZQCS, 16'h0000);
            waitFor(zqBusy, 1'b0);
            `CHK("zq duration", 1'b1, cyc - t0 <= 1 + `T_ZQCS_NCK)
            `CHK("impCode step", 6'h20 + i, impCode)
            `CHK("mprActive", 1'b0, mprActive)
        end
        waitFor(zqDue, 1'b1);
        `CHK("zq spacing", 1'b1, cyc - t0 >= ZQ_GAP - 2 && cyc - t0 <= ZQ_GAP + 2)
        $display("calibration test done");
        for (int i = 0; i < 3; i++) begin
            @(posedge mclk);
            temp <= temp_range_e'(i);
            r = `FLOOR_CYC(`T_REFI_NORMAL_NS) >> i;
            waitFor(refreshDue, 1'b1);
            // the first interval after a range change may still run at the old rate
            repeat (2) begin
                tw = cyc;
                @(posedge mclk);
                issue(CMD_REF, 16'h0000);
                waitFor(refreshDue, 1'b1);
            end
            `CHK("refresh interval", 1'b1, cyc - tw >= r - 1 && cyc - tw <= r + 4)
        end
        waitFor(refreshOverdue, 1'b1);
        `CHK("overdue", 1'b1, cyc - t0 >= 9 * r && cyc - t0 <= 9 * r + 3)
        $display("refresh test done");
        conclude();
    end
endmodule // ddr3_command_timing_notes_tb_top
